// ---- include/dctc_pkg.sv ----
package dctc_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [15:0] DCTC_TIMING1_OFS  = 16'h0114;
   localparam logic [31:0] DCTC_TIMING1_RST  = 32'h00006111;
   // Bits that hold real fields; everything else is reserved and reads zero.
   localparam logic [31:0] DCTC_TIMING1_MASK = 32'h30F3F800;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int DCTC_RTP_LSB   = 28;
   localparam int DCTC_RTP_W     = 2;
   localparam int DCTC_RAS_LSB   = 20;
   localparam int DCTC_RAS_W     = 4;
   localparam int DCTC_RRD_BIT   = 17;
   localparam int DCTC_RPALL_BIT = 16;
   localparam int DCTC_RFC_LSB   = 11;
   localparam int DCTC_RFC_W     = 5;

   // ----------------------------------------------------------------------
   // Timing counts, in memory clocks
   // ----------------------------------------------------------------------
   localparam int          DCTC_CW        = 6;
   localparam logic [5:0]  DCTC_RRD_SHORT = 6'h02;
   localparam logic [5:0]  DCTC_RRD_LONG  = 6'h03;
   localparam logic [5:0]  DCTC_BL8_HALF  = 6'h04;
   localparam logic [5:0]  DCTC_BL4_HALF  = 6'h02;
   localparam logic [5:0]  DCTC_AGE_MAX   = 6'h3F;

   // ----------------------------------------------------------------------
   // Commands reported by the scheduler
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      DCTC_CMD_NOP,
      DCTC_CMD_ACT,
      DCTC_CMD_RD,
      DCTC_CMD_WR,
      DCTC_CMD_PRE,
      DCTC_CMD_PREALL,
      DCTC_CMD_REF
   } dctc_cmd_t;

endpackage

// ---- hdl/dctc_gap_cnt.sv ----
`timescale 1ns/10ps
module dctc_gap_cnt
   import dctc_pkg::*;
#(
   parameter int CW = DCTC_CW
)(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // Start of a gap and its length in clocks
   input  wire logic          load,
   input  wire logic [CW-1:0] gap,
   // High when the gap will have elapsed after this edge
   output logic               done_nxt
);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;

   // Loading gap-1 makes the next command legal exactly gap clocks later.
   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = (gap == '0) ? '0 : gap - CW'(1);
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - CW'(1);
      end
      done_nxt = (cnt_nxt == '0);
   end

   // Counter state.
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

endmodule

// ---- hdl/dctc_timing.sv ----
`timescale 1ns/10ps
// Contract
// - Read to precharge of same rank spaced by half the burst length.
// - Activate to precharge of a bank spaced by the four-bit minimum field.
// - Activates to different banks of one rank spaced two or three clocks.
// - Precharge-all to activate waits precharge period, plus one when bit set.
// - No activate to a rank until refresh cycle time after its refresh.
// - Refresh cycle time field counts linearly, zero to thirty-one clocks.
module dctc_timing
   import dctc_pkg::*;
#(
   parameter int NR = 2,
   parameter int NB = 8,
   parameter int AW = 16
)(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // Register access
   input  wire logic [AW-1:0]          reg_addr,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [3:0]             reg_be,
   input  wire logic [31:0]            reg_wdata,
   output logic      [31:0]            reg_rdata,
   // Issued commands from the scheduler
   input  wire logic                   cmd_issue,
   input  wire dctc_cmd_t              cmd_type,
   input  wire logic [$clog2(NR)-1:0]  cmd_rank,
   input  wire logic [$clog2(NB)-1:0]  cmd_bank,
   // Parameters held elsewhere in the controller
   input  wire logic                   burst_len_8,
   input  wire logic [3:0]             prech_period,
   // Spacing status, index rank*NB+bank
   output logic      [NR*NB-1:0]       act_ok,
   output logic      [NR*NB-1:0]       pre_ok
);

   // ----------------------------------------------------------------------
   // Timing register
   // ----------------------------------------------------------------------
   logic [31:0] timing_r;
   logic        hit;

   assign hit = (reg_addr == AW'(DCTC_TIMING1_OFS));

   // Byte-lane writes; the mask keeps reserved bits at zero.
   always_ff @(posedge clk) begin
      if (rst) begin
         timing_r <= DCTC_TIMING1_RST & DCTC_TIMING1_MASK;
      end else if (reg_wr && hit) begin
         for (int i = 0; i < 4; i++) begin
            if (reg_be[i]) begin
               timing_r[8*i +: 8] <= reg_wdata[8*i +: 8] & DCTC_TIMING1_MASK[8*i +: 8];
            end
         end
      end
   end

   // Read data is held until the next read; unmapped offsets return zero.
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= hit ? timing_r : 32'h00000000;
      end
   end

   // ----------------------------------------------------------------------
   // Gap lengths from the fields
   // ----------------------------------------------------------------------
   // Reserved read-to-precharge codes fall back to half the burst, the only
   // defined spacing, so a bad write can never shorten it.
   function automatic logic [5:0] half_burst(input logic bl8);
      half_burst = bl8 ? DCTC_BL8_HALF : DCTC_BL4_HALF;
   endfunction

   logic [5:0] gap_rtp;
   logic [5:0] gap_ras;
   logic [5:0] gap_rrd;
   logic [5:0] gap_rpall;
   logic [5:0] gap_rfc;

   assign gap_rtp   = half_burst(burst_len_8);
   assign gap_ras   = {2'b00, timing_r[DCTC_RAS_LSB +: DCTC_RAS_W]};
   assign gap_rrd   = timing_r[DCTC_RRD_BIT] ? DCTC_RRD_LONG : DCTC_RRD_SHORT;
   assign gap_rpall = {2'b00, prech_period} + {5'b00000, timing_r[DCTC_RPALL_BIT]};
   assign gap_rfc   = {1'b0, timing_r[DCTC_RFC_LSB +: DCTC_RFC_W]};

   // ----------------------------------------------------------------------
   // Per-rank and per-bank spacing counters
   // ----------------------------------------------------------------------
   logic [NR-1:0]    rtp_done;
   logic [NR-1:0]    rrd_done;
   logic [NR-1:0]    rpall_done;
   logic [NR-1:0]    rfc_done;
   logic [NR*NB-1:0] ras_done;

   for (genvar r = 0; r < NR; r++) begin : g_rank
      logic hit_rank;
      assign hit_rank = cmd_issue && (cmd_rank == r);

      dctc_gap_cnt u_rtp (
         .clk      (clk),
         .rst      (rst),
         .load     (hit_rank && cmd_type == DCTC_CMD_RD),
         .gap      (gap_rtp),
         .done_nxt (rtp_done[r])
      );
      dctc_gap_cnt u_rrd (
         .clk      (clk),
         .rst      (rst),
         .load     (hit_rank && cmd_type == DCTC_CMD_ACT),
         .gap      (gap_rrd),
         .done_nxt (rrd_done[r])
      );
      dctc_gap_cnt u_rpall (
         .clk      (clk),
         .rst      (rst),
         .load     (hit_rank && cmd_type == DCTC_CMD_PREALL),
         .gap      (gap_rpall),
         .done_nxt (rpall_done[r])
      );
      dctc_gap_cnt u_rfc (
         .clk      (clk),
         .rst      (rst),
         .load     (hit_rank && cmd_type == DCTC_CMD_REF),
         .gap      (gap_rfc),
         .done_nxt (rfc_done[r])
      );

      for (genvar b = 0; b < NB; b++) begin : g_bank
         dctc_gap_cnt u_ras (
            .clk      (clk),
            .rst      (rst),
            .load     (hit_rank && cmd_bank == b && cmd_type == DCTC_CMD_ACT),
            .gap      (gap_ras),
            .done_nxt (ras_done[r*NB+b])
         );
      end
   end

   // ----------------------------------------------------------------------
   // Registered permissions
   // ----------------------------------------------------------------------
   // Built from the counters' next values so the flops add no extra clock.
   always_ff @(posedge clk) begin
      if (rst) begin
         act_ok <= '1;
         pre_ok <= '1;
      end else begin
         for (int i = 0; i < NR*NB; i++) begin
            pre_ok[i] <= ras_done[i] && rtp_done[i/NB];
            act_ok[i] <= rrd_done[i/NB] && rpall_done[i/NB] && rfc_done[i/NB];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks on rank 0, bank 0, and on the timing register
   // ----------------------------------------------------------------------
   logic [5:0] age_rd_r;
   logic [5:0] age_act0_r;
   logic [5:0] age_act_r;
   logic [5:0] age_pall_r;
   logic [5:0] age_ref_r;
   logic       r0;

   assign r0 = cmd_issue && (cmd_rank == '0);

   // Clocks since each command; one in the cycle after the command.
   always_ff @(posedge clk) begin
      if (rst) begin
         age_rd_r   <= DCTC_AGE_MAX;
         age_act0_r <= DCTC_AGE_MAX;
         age_act_r  <= DCTC_AGE_MAX;
         age_pall_r <= DCTC_AGE_MAX;
         age_ref_r  <= DCTC_AGE_MAX;
      end else begin
         age_rd_r   <= (r0 && cmd_type == DCTC_CMD_RD) ? 6'h01
                       : (age_rd_r == DCTC_AGE_MAX ? age_rd_r : age_rd_r + 6'h01);
         age_act0_r <= (r0 && cmd_type == DCTC_CMD_ACT && cmd_bank == '0) ? 6'h01
                       : (age_act0_r == DCTC_AGE_MAX ? age_act0_r : age_act0_r + 6'h01);
         age_act_r  <= (r0 && cmd_type == DCTC_CMD_ACT) ? 6'h01
                       : (age_act_r == DCTC_AGE_MAX ? age_act_r : age_act_r + 6'h01);
         age_pall_r <= (r0 && cmd_type == DCTC_CMD_PREALL) ? 6'h01
                       : (age_pall_r == DCTC_AGE_MAX ? age_pall_r : age_pall_r + 6'h01);
         age_ref_r  <= (r0 && cmd_type == DCTC_CMD_REF) ? 6'h01
                       : (age_ref_r == DCTC_AGE_MAX ? age_ref_r : age_ref_r + 6'h01);
      end
   end

   a_rtp_gap: assert property (@(posedge clk) disable iff (rst)
      pre_ok[0] |-> age_rd_r >= gap_rtp)
      else $error("Precharge allowed too soon after read.");
   a_ras_gap: assert property (@(posedge clk) disable iff (rst)
      pre_ok[0] |-> age_act0_r >= gap_ras)
      else $error("Precharge allowed too soon after activate.");
   a_rrd_gap: assert property (@(posedge clk) disable iff (rst)
      act_ok[0] |-> age_act_r >= gap_rrd)
      else $error("Activate allowed too soon after activate.");
   a_rpall_gap: assert property (@(posedge clk) disable iff (rst)
      act_ok[0] |-> age_pall_r >= gap_rpall)
      else $error("Activate allowed too soon after precharge-all.");
   a_rfc_gap: assert property (@(posedge clk) disable iff (rst)
      act_ok[0] |-> age_ref_r >= gap_rfc)
      else $error("Activate allowed too soon after refresh.");
   a_rfc_exact: assert property (@(posedge clk) disable iff (rst)
      $rose(rfc_done[0]) && (age_ref_r < DCTC_AGE_MAX) |-> age_ref_r + 6'h01 == gap_rfc)
      else $error("Refresh gap does not end at the programmed count.");
   a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
      (reg_rdata & ~DCTC_TIMING1_MASK) == 32'h00000000)
      else $error("Reserved bits read nonzero.");
   a_wr_takes: assert property (@(posedge clk) disable iff (rst)
      reg_wr && hit && reg_be == 4'hF |=> timing_r == ($past(reg_wdata) & DCTC_TIMING1_MASK))
      else $error("Full write did not update the timing fields.");

   c_ref_block: cover property (@(posedge clk) disable iff (rst)
      r0 && cmd_type == DCTC_CMD_REF ##1 !act_ok[0] [*3] ##[1:40] act_ok[0]);
   c_ras_block: cover property (@(posedge clk) disable iff (rst)
      r0 && cmd_type == DCTC_CMD_ACT && cmd_bank == '0 ##1 !pre_ok[0] ##[1:20] pre_ok[0]);
   c_reg_write: cover property (@(posedge clk) disable iff (rst)
      reg_wr && hit ##1 reg_rd && hit);

endmodule

// ---- test/dctc_cmd_src.sv ----
`timescale 1ns/10ps
// Scheduler stand-in: one command per call, issued only once the bench has
// seen the spacing outputs clear again, as the real scheduler must.
module dctc_cmd_src
   import dctc_pkg::*;
(
   // Clock
   input  wire logic  clk,
   // Command port
   output dctc_cmd_t  cmd_type,
   output logic       cmd_issue,
   output logic [0:0] cmd_rank,
   output logic [2:0] cmd_bank
);
   // Start idle so that no command is seen before the first call.
   initial begin
      cmd_issue = 1'b0;
      cmd_type  = DCTC_CMD_NOP;
      cmd_rank  = 1'b0;
      cmd_bank  = 3'h0;
   end
   // Drive a command for exactly one cycle, then scramble the bank so a stale value is never reused.
   task automatic send(input dctc_cmd_t t, input logic [0:0] r, input logic [2:0] b);
      @(negedge clk);
      cmd_type  = t;
      cmd_rank  = r;
      cmd_bank  = b;
      cmd_issue = 1'b1;
      @(negedge clk);
      cmd_issue = 1'b0;
      cmd_type  = DCTC_CMD_NOP;
      cmd_bank  = ~b;
   endtask
endmodule

// ---- test/dctc_timing_tb.sv ----
`timescale 1ns/10ps
module dctc_timing_tb
   import dctc_pkg::*;
;
   // ----------------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------------
   logic        clk, rst, reg_wr, reg_rd, burst_len_8, cmd_issue;
   logic [15:0] reg_addr, act_ok, pre_ok;
   logic [3:0]  reg_be, prech_period;
   logic [31:0] reg_wdata, reg_rdata;
   logic [0:0]  cmd_rank;
   logic [2:0]  cmd_bank;
   dctc_cmd_t   cmd_type;
   int          failures, n_checks;
   logic [4:0]  rfc_tab [8] = '{5'h00, 5'h01, 5'h0D, 5'h14, 5'h0F, 5'h15, 5'h1A, 5'h1F};
   logic [3:0]  ras_tab [5] = '{4'h7, 4'h9, 4'hC, 4'hF, 4'h0};

   dctc_timing dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmd_issue(cmd_issue),
      .cmd_type(cmd_type), .cmd_rank(cmd_rank), .cmd_bank(cmd_bank), .burst_len_8(burst_len_8),
      .prech_period(prech_period), .act_ok(act_ok), .pre_ok(pre_ok));
   dctc_cmd_src src_u (.clk(clk), .cmd_type(cmd_type), .cmd_issue(cmd_issue), .cmd_rank(cmd_rank),
      .cmd_bank(cmd_bank));

   // Free-running 250 MHz clock.
   initial clk = 1'b0;
   always #2 clk = ~clk;

   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_be    = be;
      reg_wr    = 1'b1;
      @(negedge clk);
      reg_wr    = 1'b0;
      reg_wdata = ~d;
   endtask
   // Read data is looked at on the falling edge half a cycle after the taking edge, where it stands.
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      @(negedge clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk(reg_rdata, exp);
   endtask
   task automatic prog(input logic [1:0] rtp, input logic [3:0] ras, input logic rrd, input logic pall,
                       input logic [4:0] rfc);
      wr(16'h0114, {2'b00, rtp, 4'h0, ras, 2'b00, rrd, pall, rfc, 11'h000}, 4'hF);
   endtask
   // Count the cycles an ok bit stays low after a command; the bound guards against a hang.
   task automatic gap(input dctc_cmd_t t, input logic [0:0] r, input logic [2:0] b, input logic pre,
                      input int idx, input int exp);
      int n;
      n = 0;
      src_u.send(t, r, b);
      while ((pre ? pre_ok[idx] : act_ok[idx]) !== 1'b1) begin
         n++;
         if (n > 100) begin
            failures++;
            $display("CHECK FAILED at %0t: ok bit stuck low", $time);
            wrap_up();
         end
         @(negedge clk);
      end
      chk(n, exp);
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_be = 4'h0;
      reg_wdata = 32'h00000000;
      burst_len_8 = 1'b0;
      prech_period = 4'h5;
      failures = 0;
      n_checks = 0;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      rd(16'h0114, 32'h00006000);
      rd(16'h0118, 32'h00000000);
      wr(16'h0114, 32'hFFFFFFFF, 4'hF);
      rd(16'h0114, 32'h30F3F800);
      wr(16'h0114, 32'h00000000, 4'h8);
      wr(16'h0118, 32'h00000000, 4'hF);
      rd(16'h0114, 32'h00F3F800);
      // Refresh gap over a spread of codes, including both field ends.
      foreach (rfc_tab[i]) begin
         prog(2'b00, 4'h0, 1'b0, 1'b0, rfc_tab[i]);
         gap(DCTC_CMD_REF, 1'b1, 3'h2, 1'b0, 13, (rfc_tab[i] > 1) ? rfc_tab[i] - 1 : 0);
      end
      foreach (ras_tab[i]) begin
         prog(2'b00, ras_tab[i], 1'b0, 1'b0, 5'h00);
         gap(DCTC_CMD_ACT, 1'b0, 3'h3, 1'b1, 3, (ras_tab[i] > 1) ? ras_tab[i] - 1 : 0);
      end
      for (int k = 0; k < 2; k++) begin
         prog(2'b00, 4'h0, k[0], 1'b0, 5'h00);
         gap(DCTC_CMD_ACT, 1'b0, 3'h0, 1'b0, 1, 1 + k);
         // The second pass also lengthens the precharge period, from 5 to 9 clocks.
         prech_period = 4'h5 + 4'(4 * k);
         prog(2'b00, 4'h0, 1'b0, k[0], 5'h00);
         gap(DCTC_CMD_PREALL, 1'b1, 3'h0, 1'b0, 8, 4 + 5 * k);
         burst_len_8 = k[0];
         prog(2'b00, 4'h0, 1'b0, 1'b0, 5'h00);
         gap(DCTC_CMD_RD, 1'b0, 3'h6, 1'b1, 0, 1 + 2 * k);
         prog(2'b11, 4'h0, 1'b0, 1'b0, 5'h00);
         gap(DCTC_CMD_RD, 1'b0, 3'h6, 1'b1, 0, 1 + 2 * k);
      end
      // Write and idle slots must not start any gap.
      gap(DCTC_CMD_WR, 1'b0, 3'h0, 1'b1, 0, 0);
      gap(DCTC_CMD_NOP, 1'b0, 3'h0, 1'b0, 0, 0);
      // Rank 0 gaps, the ones the design's own checks watch; refresh field at its top code.
      prog(2'b00, 4'h0, 1'b0, 1'b0, 5'h1F);
      gap(DCTC_CMD_PREALL, 1'b0, 3'h0, 1'b0, 2, 8);
      gap(DCTC_CMD_REF, 1'b0, 3'h0, 1'b0, 5, 30);
      // Reset in the middle of a refresh gap clears the counters and returns the register to its reset value.
      src_u.send(DCTC_CMD_REF, 1'b0, 3'h0);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      chk({16'h0000, act_ok}, 32'h0000FFFF);
      // One edge later a counter that kept its count would already pull the bits low.
      @(negedge clk);
      chk({16'h0000, act_ok}, 32'h0000FFFF);
      rd(16'h0114, 32'h00006000);
      wrap_up();
   end
endmodule
